// *** inc/psc_pkg.sv ***
// psc_pkg: offsets, field positions and encodings of the status,
// control and flag registers.
// assumes a byte-wide register port decoded by the serial bus front end.
//
// Summary of operation
// RULE_01: status bit 7 reads 0 while seal intact, 1 once broken
// RULE_02: status bit 6 reads 1 when non-volatile defaults differ from factory
// RULE_03: status bit 5 is adapter-detect pin inverted
// RULE_04: status bit 4 is push-button pin inverted
// RULE_05: status bits 3-2 give state: transitional, wait, active, suspend
// RULE_06: status bits 1-0 give coin-cell level, low to above ideal
// RULE_07: host triggers a measurement before trusting coin-cell level bits
// RULE_08: writing 1 to control bit 0 starts measurement; bit self-clears
// RULE_09: control bit 1 set and power-fail low shuts all rails off
// RULE_10: control bit 1 clear leaves power state unaffected by power-fail
// RULE_11: flag bit set on wake from suspend with output enabled in suspend
// RULE_12: flags 7-5 general outputs 3-1, 4 linear reg, 3-1 converters 4-2
// RULE_13: flag bit 0 records converter 1 the same way
// RULE_14: status and flag reads have no side effect; writes ignored
// RULE_15: control bits 7-2 read 0 and ignore writes
`default_nettype none

package psc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] PSC_ADDR_STATUS  = 8'h05;
   localparam logic [7:0] PSC_ADDR_CONTROL = 8'h06;
   localparam logic [7:0] PSC_ADDR_FLAG    = 8'h07;
   localparam logic [7:0] PSC_RST_CONTROL  = 8'h00;
   localparam logic [7:0] PSC_RST_FLAG     = 8'h00;
   localparam logic [7:0] PSC_RD_NONE      = 8'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PSC_ST_SEAL_BIT   = 7;
   localparam int PSC_ST_NVM_BIT    = 6;
   localparam int PSC_ST_AC_BIT     = 5;
   localparam int PSC_ST_PB_BIT     = 4;
   localparam int PSC_ST_STATE_LSB  = 2;
   localparam int PSC_ST_CC_LSB     = 0;
   localparam int PSC_CT_MEAS_BIT   = 0;
   localparam int PSC_CT_PFSD_BIT   = 1;
   localparam int PSC_NUM_RAILS     = 8;

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [1:0] PSC_STATE_TRANS   = 2'h0;
   localparam logic [1:0] PSC_STATE_WAIT    = 2'h1;
   localparam logic [1:0] PSC_STATE_ACTIVE  = 2'h2;
   localparam logic [1:0] PSC_STATE_SUSPEND = 2'h3;

   // internal power state sequence tracked by this block
   typedef enum logic [2:0] {
      PSC_PS_OFF,
      PSC_PS_WAIT,
      PSC_PS_UP,
      PSC_PS_ACTIVE,
      PSC_PS_DOWN,
      PSC_PS_SUSPEND
   } psc_pstate_t;
endpackage : psc_pkg

`default_nettype wire

// *** rtl/psc_flags.sv ***
// psc_flags: status, control and suspend flag registers of the power
// manager, plus a small power state tracker for the state field.
// assumes a byte register port from the serial bus front end, sequencer
// requests as one-cycle pulses and the coin-cell measurement done pulse.
`default_nettype none

module psc_flags (
   // clock and reset
   input  wire logic                     ref_clk_i,
   input  wire logic                     rstn_i,
   // register port
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   output logic      [7:0]               reg_rdata_o,
   // nvm and seal state
   input  wire logic                     freshness_seal_i,
   input  wire logic                     nvm_modified_i,
   // pins
   input  wire logic                     adapter_detect_pin_i,
   input  wire logic                     push_button_pin_i,
   input  wire logic                     power_fail_output_i,
   // sequencer events
   input  wire logic                     seq_power_en_i,
   input  wire logic                     seq_up_done_i,
   input  wire logic                     seq_suspend_req_i,
   input  wire logic                     seq_down_done_i,
   input  wire logic                     seq_wake_i,
   input  wire logic                     seq_off_req_i,
   input  wire logic [psc_pkg::PSC_NUM_RAILS-1:0] rail_en_i,
   // coin-cell measurement
   input  wire logic                     coin_cell_done_i,
   input  wire logic [1:0]               coin_cell_level_i,
   output logic                          coin_cell_measure_start_o,
   // shutdown
   output logic                          rails_shutdown_o,
   output logic [1:0]                    power_state_o
);
   import psc_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   psc_pstate_t                  ps_reg;
   psc_pstate_t                  ps_next;
   logic                         pfsd_en_reg;
   logic                         meas_start_reg;
   logic [1:0]                   cc_level_reg;
   logic [PSC_NUM_RAILS-1:0]     flag_reg;
   logic                         pf_trip;

   // register hit decode, used by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   // power-fail trips only when armed
   assign pf_trip = pfsd_en_reg & ~power_fail_output_i;  // RULE_09 RULE_10

   // ------------------------------------------------------------
   // power state tracker
   // ------------------------------------------------------------
   always_comb begin
      ps_next = ps_reg;
      unique case (ps_reg)
         PSC_PS_OFF:     if (seq_power_en_i) ps_next = PSC_PS_UP;
         PSC_PS_WAIT:    if (seq_power_en_i) ps_next = PSC_PS_UP;
         PSC_PS_UP:      if (seq_up_done_i) ps_next = PSC_PS_ACTIVE;
         PSC_PS_ACTIVE:  if (seq_suspend_req_i) ps_next = PSC_PS_DOWN;
         PSC_PS_DOWN:    if (seq_down_done_i) ps_next = PSC_PS_SUSPEND;
         PSC_PS_SUSPEND: if (seq_wake_i) ps_next = PSC_PS_UP;
      endcase
      if (seq_off_req_i) begin
         ps_next = PSC_PS_WAIT;
      end
      // armed power-fail overrides any sequencer request
      if (pf_trip) begin
         ps_next = PSC_PS_OFF;  // RULE_09
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ps_reg <= PSC_PS_OFF;
      end else begin
         ps_reg <= ps_next;
      end
   end

   // off and wait both report as waiting for power enable
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_state_o    <= PSC_STATE_TRANS;
         rails_shutdown_o <= 1'b0;
      end else begin
         unique case (ps_next)
            PSC_PS_OFF,
            PSC_PS_WAIT:    power_state_o <= PSC_STATE_WAIT;
            PSC_PS_ACTIVE:  power_state_o <= PSC_STATE_ACTIVE;  // RULE_05
            PSC_PS_SUSPEND: power_state_o <= PSC_STATE_SUSPEND;
            default:        power_state_o <= PSC_STATE_TRANS;
         endcase
         rails_shutdown_o <= pf_trip;  // RULE_09
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pfsd_en_reg <= PSC_RST_CONTROL[PSC_CT_PFSD_BIT];
      end else if (reg_wr_i && hit(reg_addr_i, PSC_ADDR_CONTROL)) begin
         pfsd_en_reg <= reg_wdata_i[PSC_CT_PFSD_BIT];  // RULE_15
      end
   end

   // start is a one-cycle pulse: the bit never holds, writing 0 is a no-op
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meas_start_reg <= PSC_RST_CONTROL[PSC_CT_MEAS_BIT];
      end else begin
         meas_start_reg <= reg_wr_i & hit(reg_addr_i, PSC_ADDR_CONTROL)
                           & reg_wdata_i[PSC_CT_MEAS_BIT];  // RULE_08
      end
   end
   assign coin_cell_measure_start_o = meas_start_reg;

   // level is held from the last completed measurement only
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cc_level_reg <= PSC_STATE_TRANS;
      end else if (coin_cell_done_i) begin
         cc_level_reg <= coin_cell_level_i;  // RULE_06 RULE_07
      end
   end

   // ------------------------------------------------------------
   // suspend flags
   // ------------------------------------------------------------
   // enables seen on the wake edge are still the suspend settings, so they
   // are published directly; a power-up from off or wait clears them
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_reg    <= PSC_RST_FLAG;
      end else begin
         if (ps_reg == PSC_PS_SUSPEND && seq_wake_i && !pf_trip
             && !seq_off_req_i) begin
            flag_reg <= rail_en_i;  // RULE_11 RULE_12 RULE_13
         end else if ((ps_reg == PSC_PS_OFF || ps_reg == PSC_PS_WAIT)
                      && seq_power_en_i) begin
            flag_reg <= PSC_RST_FLAG;  // RULE_11
         end
      end
   end

   // ------------------------------------------------------------
   // read path, no read side effects
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= PSC_RD_NONE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= PSC_RD_NONE;  // RULE_14
         if (hit(reg_addr_i, PSC_ADDR_STATUS)) begin
            reg_rdata_o[PSC_ST_SEAL_BIT] <= freshness_seal_i;      // RULE_01
            reg_rdata_o[PSC_ST_NVM_BIT]  <= nvm_modified_i;        // RULE_02
            reg_rdata_o[PSC_ST_AC_BIT]   <= ~adapter_detect_pin_i; // RULE_03
            reg_rdata_o[PSC_ST_PB_BIT]   <= ~push_button_pin_i;    // RULE_04
            reg_rdata_o[PSC_ST_STATE_LSB +: 2] <= power_state_o;   // RULE_05
            reg_rdata_o[PSC_ST_CC_LSB +: 2]    <= cc_level_reg;    // RULE_06
         end else if (hit(reg_addr_i, PSC_ADDR_CONTROL)) begin
            reg_rdata_o[PSC_CT_PFSD_BIT] <= pfsd_en_reg;           // RULE_15
         end else if (hit(reg_addr_i, PSC_ADDR_FLAG)) begin
            reg_rdata_o <= flag_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // a single clock domain, so every check shares one clock and reset
   default clocking chk_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // helper terms shared by the checks below
   logic chk_meas_wr;
   logic chk_rd_status;
   logic chk_rd_control;
   logic chk_rd_mapped;
   logic chk_seq_idle;

   assign chk_meas_wr    = reg_wr_i && hit(reg_addr_i, PSC_ADDR_CONTROL)
                           && reg_wdata_i[PSC_CT_MEAS_BIT];
   assign chk_rd_status  = reg_rd_i && hit(reg_addr_i, PSC_ADDR_STATUS);
   assign chk_rd_control = reg_rd_i && hit(reg_addr_i, PSC_ADDR_CONTROL);
   assign chk_rd_mapped  = hit(reg_addr_i, PSC_ADDR_STATUS)
                           || hit(reg_addr_i, PSC_ADDR_CONTROL)
                           || hit(reg_addr_i, PSC_ADDR_FLAG);
   // no sequencer request at all, so only power-fail could move the state
   assign chk_seq_idle   = !(seq_power_en_i || seq_up_done_i
                             || seq_suspend_req_i || seq_down_done_i
                             || seq_wake_i || seq_off_req_i);

   // back-to-back start writes legally give back-to-back pulses
   chk_meas_pulse: assert property ( // RULE_08
      coin_cell_measure_start_o && !chk_meas_wr
      |=> !coin_cell_measure_start_o)
      else $error("measure start held longer than one cycle");

   chk_meas_cause: assert property ( // RULE_08
      chk_meas_wr |=> coin_cell_measure_start_o)
      else $error("measure start not issued");

   // a zero in the start bit, or any other access, starts nothing
   chk_meas_zero: assert property ( // RULE_08
      !chk_meas_wr
      |=> !coin_cell_measure_start_o)
      else $error("measure start without a request");

   chk_cc_capture: assert property ( // RULE_06 RULE_07
      coin_cell_done_i |=> cc_level_reg == $past(coin_cell_level_i))
      else $error("coin-cell level not taken on done");

   // power-fail: armed trips shut everything off, disarmed changes nothing
   chk_pf_off: assert property ( // RULE_09
      pfsd_en_reg && !power_fail_output_i
      |=> rails_shutdown_o && ps_reg == PSC_PS_OFF)
      else $error("armed power fail did not shut down");

   chk_pf_ignored: assert property ( // RULE_10
      !pfsd_en_reg |=> !rails_shutdown_o)
      else $error("power fail acted while disarmed");

   chk_pf_hold: assert property ( // RULE_10
      !pfsd_en_reg && !power_fail_output_i && chk_seq_idle
      |=> $stable(ps_reg))
      else $error("disarmed power fail moved the power state");

   // status reads: pins inverted, seal and nvm straight, state coded
   chk_status_pins: assert property ( // RULE_03 RULE_04
      chk_rd_status
      |=> reg_rdata_o[PSC_ST_AC_BIT] == !$past(adapter_detect_pin_i)
          && reg_rdata_o[PSC_ST_PB_BIT] == !$past(push_button_pin_i))
      else $error("status pin bits wrong");

   chk_status_seal: assert property ( // RULE_01 RULE_02
      chk_rd_status
      |=> reg_rdata_o[PSC_ST_SEAL_BIT] == $past(freshness_seal_i)
          && reg_rdata_o[PSC_ST_NVM_BIT] == $past(nvm_modified_i))
      else $error("seal or nvm bit wrong");

   chk_status_active: assert property ( // RULE_05
      chk_rd_status && ps_reg == PSC_PS_ACTIVE
      |=> reg_rdata_o[PSC_ST_STATE_LSB +: 2] == PSC_STATE_ACTIVE)
      else $error("active state not read back");

   chk_state_susp: assert property ( // RULE_05
      ps_reg == PSC_PS_SUSPEND |-> power_state_o == PSC_STATE_SUSPEND)
      else $error("suspend state not reported");

   // control reads: only the shutdown enable can ever read as one
   chk_ctrl_rsvd: assert property ( // RULE_15
      chk_rd_control
      |=> reg_rdata_o[7:2] == 6'h00 && !reg_rdata_o[PSC_CT_MEAS_BIT])
      else $error("control reserved bits not zero");

   chk_ctrl_enable: assert property ( // RULE_09 RULE_15
      chk_rd_control |=> reg_rdata_o[PSC_CT_PFSD_BIT] == $past(pfsd_en_reg))
      else $error("shutdown enable not read back");

   // unmapped addresses read as zero and leave no trace
   chk_rd_unmapped: assert property ( // RULE_14
      reg_rd_i && !chk_rd_mapped |=> reg_rdata_o == PSC_RD_NONE)
      else $error("unmapped read not zero");

   // flags: cleared on power-up from off or wait, captured on wake only
   chk_flag_cold: assert property ( // RULE_11
      (ps_reg == PSC_PS_OFF || ps_reg == PSC_PS_WAIT) && seq_power_en_i
      |=> flag_reg == PSC_RST_FLAG)
      else $error("flags not cleared on power-up from off");

   chk_flag_wake: assert property ( // RULE_11 RULE_12 RULE_13
      ps_reg == PSC_PS_SUSPEND && seq_wake_i && !pf_trip && !seq_off_req_i
      |=> flag_reg == $past(rail_en_i))
      else $error("flags not captured on wake");

   chk_flag_write: assert property ( // RULE_14
      reg_wr_i && hit(reg_addr_i, PSC_ADDR_FLAG) && chk_seq_idle
      |=> $stable(flag_reg))
      else $error("flag register changed by a host write");

   // main scenarios the bench is expected to reach
   cov_wake: cover property (
      ps_reg == PSC_PS_SUSPEND ##1 ps_reg == PSC_PS_UP);
   cov_pf_trip: cover property (pf_trip);
   cov_meas: cover property (
      coin_cell_measure_start_o ##[1:20] coin_cell_done_i);
   cov_active: cover property (power_state_o == PSC_STATE_ACTIVE);
   cov_flag_set: cover property (
      ps_reg == PSC_PS_SUSPEND && seq_wake_i && rail_en_i != PSC_RST_FLAG);
endmodule : psc_flags

`default_nettype wire

// *** dv/psc_coin_model.sv ***
// psc_coin_model: coin-cell measurement unit on the far side of the
// measurement start pulse. assumes a one-cycle start from the block.
`default_nettype none

module psc_coin_model (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rstn_i,
   // bench settings
   input  wire logic [3:0] lat_i,
   input  wire logic [1:0] level_sel_i,
   // measurement handshake
   input  wire logic       start_i,
   output logic            done_o,
   output logic [1:0]      level_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_reg;
   logic [1:0] last_reg;

   // conversion time is lat_i+1 cycles, so both prompt and slow answers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg  <= 5'h00;
         last_reg <= 2'h0;
      end else begin
         last_reg <= level_o;
         if (start_i) begin
            cnt_reg <= {1'b0, lat_i} + 5'h01;
         end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
         end
      end
   end

   // result is only valid in the done cycle; otherwise it toggles
   assign done_o  = (cnt_reg == 5'h01);
   assign level_o = done_o ? level_sel_i : ~last_reg;
endmodule : psc_coin_model

`default_nettype wire

// *** dv/psc_flags_tb.sv ***
// psc_flags_tb: self-checking bench of the status, control and flag
// registers. assumes psc_pkg and the coin-cell model psc_coin_model.
`default_nettype none

module psc_flags_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import psc_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, rail_en = 8'h00, r;
   logic        seal = 1'b0, nvm = 1'b0, ac = 1'b1, pb = 1'b1, pf = 1'b1;
   logic [5:0]  seq = 6'h00;
   logic        cc_done, cc_start, shut, rd_d = 1'b0;
   logic [1:0]  cc_lvl, pstate, lvl_sel = 2'h0;
   logic [3:0]  lat = 4'h0;
   logic [31:0] seed = 32'h0AF3338D;
   logic [7:0]  exp_q[$];
   int          n_fail = 0, cmp_count = 0, i, k;

   always #20 clk = ~clk;

   psc_flags DUT (.ref_clk_i(clk), .rstn_i(rstn), .reg_wr_i(wr_s),
      .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .freshness_seal_i(seal), .nvm_modified_i(nvm),
      .adapter_detect_pin_i(ac), .push_button_pin_i(pb),
      .power_fail_output_i(pf), .seq_power_en_i(seq[0]),
      .seq_up_done_i(seq[1]), .seq_suspend_req_i(seq[2]),
      .seq_down_done_i(seq[3]), .seq_wake_i(seq[4]), .seq_off_req_i(seq[5]),
      .rail_en_i(rail_en), .coin_cell_done_i(cc_done),
      .coin_cell_level_i(cc_lvl), .coin_cell_measure_start_o(cc_start),
      .rails_shutdown_o(shut), .power_state_o(pstate));

   psc_coin_model u_coin (.ref_clk_i(clk), .rstn_i(rstn), .lat_i(lat),
      .level_sel_i(lvl_sel), .start_i(cc_start), .done_o(cc_done),
      .level_o(cc_lvl));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // expected status byte from the live inputs the bench is driving
   function automatic logic [7:0] stat(input logic [1:0] st,
                                       input logic [1:0] cc);
      return {seal, nvm, ~ac, ~pb, st, cc};
   endfunction : stat

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // direct output pins: start pulse, shutdown and state code
   task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t out got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_out

   task automatic wrap_up();
      if (exp_q.size() != 0) n_fail++;
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // each bus task leaves one edge before raising its strobe again
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s  <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd_s <= 1'b0;
   endtask : rd

   task automatic pulse(input int n);
      @(posedge clk);
      seq <= 6'(1 << n);
      @(posedge clk);
      seq <= 6'h00;
   endtask : pulse

   // read data is registered, so it is judged one cycle after the strobe
   always @(posedge clk) rd_d <= rd_s;
   always @(negedge clk) begin
      if (rd_d && exp_q.size() != 0) cmp(rdata, exp_q.pop_front());
   end

   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(PSC_ADDR_CONTROL, PSC_RST_CONTROL);
      rd(PSC_ADDR_FLAG, PSC_RST_FLAG);
      for (i = 0; i < 6; i++) begin
         {seal, nvm, ac, pb} <= 4'(xs());
         repeat (2) @(posedge clk);
         r = stat(PSC_STATE_WAIT, 2'h0);
         rd(PSC_ADDR_STATUS, r);
      end
      $display("test status_inputs done");
      // every coin level, reserved bits written high, random latency
      for (i = 0; i < 4; i++) begin
         lvl_sel <= 2'(i);
         lat <= 4'(xs());
         wr(PSC_ADDR_CONTROL, 8'hFD);
         @(negedge clk);
         cmp_out({7'h00, cc_start}, 8'h01);
         for (k = 0; k < 40 && cc_done !== 1'b1; k++) @(negedge clk);
         if (k == 40) begin
            n_fail++;
            wrap_up();
         end
         @(posedge clk);
         rd(PSC_ADDR_STATUS, stat(PSC_STATE_WAIT, 2'(i)));
         rd(PSC_ADDR_CONTROL, 8'h00);
      end
      wr(PSC_ADDR_CONTROL, 8'h00);
      @(negedge clk);
      cmp_out({7'h00, cc_start}, 8'h00);
      $display("test coin_cell done");
      wr(PSC_ADDR_STATUS, 8'hFF);
      wr(PSC_ADDR_FLAG, 8'hFF);
      wr(8'h2A, 8'hFF);
      rd(PSC_ADDR_FLAG, 8'h00);
      rd(8'h2A, PSC_RD_NONE);
      rd(PSC_ADDR_STATUS, stat(PSC_STATE_WAIT, 2'h3));
      rd(PSC_ADDR_STATUS, stat(PSC_STATE_WAIT, 2'h3));
      $display("test ignored_access done");
      // suspend cycles; rails change after wake to prove the flags hold
      for (i = 0; i < 3; i++) begin
         pulse(0);
         rd(PSC_ADDR_FLAG, 8'h00);
         pulse(1);
         @(negedge clk);
         cmp_out({6'h00, pstate}, {6'h00, PSC_STATE_ACTIVE});
         rd(PSC_ADDR_STATUS, stat(PSC_STATE_ACTIVE, 2'h3));
         pulse(2);
         rd(PSC_ADDR_STATUS, stat(PSC_STATE_TRANS, 2'h3));
         r = (i == 2) ? 8'h00 : 8'(xs());
         rail_en <= r;
         pulse(3);
         @(negedge clk);
         cmp_out({6'h00, pstate}, {6'h00, PSC_STATE_SUSPEND});
         rd(PSC_ADDR_STATUS, stat(PSC_STATE_SUSPEND, 2'h3));
         pulse(4);
         rail_en <= ~r;
         rd(PSC_ADDR_FLAG, r);
         pulse(1);
         pulse(5);
         rd(PSC_ADDR_STATUS, stat(PSC_STATE_WAIT, 2'h3));
      end
      $display("test suspend_flags done");
      pulse(0);
      pulse(1);
      // power-fail first unarmed, then armed
      for (i = 0; i < 2; i++) begin
         if (i == 1) wr(PSC_ADDR_CONTROL, 8'h02);
         pf <= 1'b0;
         @(posedge clk);
         @(negedge clk);
         cmp_out({7'h00, shut}, 8'(i));
         r = (i == 1) ? 8'(PSC_STATE_WAIT) : 8'(PSC_STATE_ACTIVE);
         cmp_out({6'h00, pstate}, r);
         @(posedge clk);
         pf <= 1'b1;
         r = stat((i == 1) ? PSC_STATE_WAIT : PSC_STATE_ACTIVE, 2'h3);
         rd(PSC_ADDR_STATUS, r);
      end
      rd(PSC_ADDR_CONTROL, 8'h02);
      $display("test power_fail done");
      repeat (3) @(posedge clk);
      wrap_up();
   end

   initial begin
      #800000;
      n_fail++;
      wrap_up();
   end
endmodule : psc_flags_tb

`default_nettype wire
